// *** ldd_chk_assertions.sv ***
// two-wire line checks between the host end and the led driver end
module ldd_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl,
    input wire logic sda,
    input wire logic m_scl_o,
    input wire logic m_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_dev_low_only: assert property (s_sda_oe |-> !s_sda_o)
        else $error("device drove sda high");
    a_host_scl_low: assert property (m_scl_oe |-> !m_scl_o)
        else $error("host drove scl high");
    a_host_sda_low: assert property (m_sda_oe |-> !m_sda_o)
        else $error("host drove sda high");
    // the slave may only move sda under a low clock, else it would fake start or stop
    a_dev_take_low: assert property ($rose(s_sda_oe) |-> !scl)
        else $error("device took sda while scl high");
    a_dev_free_low: assert property ($fell(s_sda_oe) |-> !scl && $past(!scl, 1))
        else $error("device released sda while scl high");
    a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
        else $error("scl low phase too short");
    a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
        else $error("scl high phase too short");
    a_idle_lines: assert property (!m_scl_oe && !m_sda_oe && !s_sda_oe |-> scl && sda)
        else $error("released lines not high");
endmodule // ldd_chk

// *** ldd_device.sv ***
// led driver digital core: two-wire slave, registers, dimming, de-rating, cutoff
// How it works
// RQ1 - bank current code, 0.125 mA per step
// RQ2 - write slave address, bank register, code
// RQ3 - register 03h bits enable six channels
// RQ4 - host sets currents before enabling channels
// RQ5 - 285 Hz pwm, 256 log 12-bit duties
// RQ6 - code FFh full duty, 00h zero
// RQ7 - outputs gated by duty from 05h
// RQ8 - de-rating lowers duty, never current codes
// RQ9 - table 56h-5Dh, two nibbles per byte
// RQ10 - 1x scale 0-7 steps, 2x 0-14
// RQ11 - host loads codes from 25 to 100 C
// RQ12 - 5-bit temperature code, 5 C steps
// RQ13 - table steps subtracted from dimming code
// RQ14 - temperature refreshed every 2.5 seconds
// RQ15 - above 4Ah limit all channels off
// RQ16 - converter serves temperature or diagnostics, not both
// RQ17 - factory table valid after reset
// RQ18 - slave works to 400 kbit/s, idle high
// RQ19 - address 11h or 55h by pin
// RQ20 - master starts everything, device acknowledges
// RQ21 - host clears enables of unused channels
// RQ22 - sticky overheat flag in 03h bit 7
// RQ23 - de-rated code saturates at zero
module ldd_device
    import ldd_pkg::*;
#(
    parameter int TEMP_PERIOD = TEMP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    ldd_if.dev bus,
    input wire logic address_select_pin_i,
    input wire logic [4:0] temp_code_i,
    input wire logic diag_req_i,
    output logic [7:0] led_current_a_o,
    output logic [7:0] led_current_b_o,
    output logic [7:0] led_current_c_o,
    output logic bank_a_out_1_o,
    output logic bank_a_out_2_o,
    output logic bank_b_out_1_o,
    output logic bank_b_out_2_o,
    output logic bank_c_out_1_o,
    output logic bank_c_out_2_o,
    output logic led_overheat_flag_o,
    output logic adc_diag_o
);
    logic [1:0] scl_s_r, sda_s_r, sel_s_r;
    logic scl_d_r, sda_d_r;
    ldd_sst_t st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, ptr_r;
    logic mack_r, wr_r, oe_r;
    logic [7:0] cur_r [3];
    logic [5:0] en_r;
    logic ot_r;
    logic [7:0] dim_r, shdn_r, dmode_r;
    logic [63:0] tab_r;
    logic [4:0] temp_r;
    logic [26:0] tmr_r;
    logic pend_r, fresh_r;
    logic pwm;
    logic [5:0] drive_nxt;

    wire scl_rise = scl_s_r[1] && !scl_d_r;
    wire scl_fall = !scl_s_r[1] && scl_d_r;
    wire start_ev = scl_s_r[1] && scl_d_r && !sda_s_r[1] && sda_d_r;
    wire stop_ev = scl_s_r[1] && scl_d_r && sda_s_r[1] && !sda_d_r;
    wire [6:0] my_addr = sel_s_r[1] ? SLV_ADDR_HI : SLV_ADDR_LO; // RQ19
    wire addr_ok = sh_r[7:1] == my_addr;
    wire byte_end = scl_fall && bit_r == BIT_ACK - 4'h1;
    wire ack_end = scl_fall && bit_r == BIT_ACK;
    wire hit_a = ptr_r == REG_CUR_A;
    wire hit_b = ptr_r == REG_CUR_B;
    wire hit_c = ptr_r == REG_CUR_C;
    wire hit_en = ptr_r == REG_CH_EN;
    wire hit_dim = ptr_r == REG_DIM;
    wire hit_sd = ptr_r == REG_SHDN;
    wire hit_dm = ptr_r == REG_DMODE;
    wire hit_tab = ptr_r >= REG_TAB0 && ptr_r <= REG_TAB7;
    wire [2:0] tab_wi = 3'(ptr_r - REG_TAB0);
    wire [7:0] tab_rd = tab_r[{tab_wi, 3'b000} +: 8];
    wire [7:0] rd_data = hit_a ? cur_r[0] : hit_b ? cur_r[1] : hit_c ? cur_r[2] :
                         hit_en ? {ot_r, 1'b0, en_r} : hit_dim ? dim_r : hit_sd ? shdn_r :
                         hit_dm ? dmode_r : hit_tab ? tab_rd : 8'h00;
    // drive ack low after each received byte, data bits while reading
    wire oe_nxt = (st_r != S_IDLE && st_r != S_RD && bit_r == BIT_ACK) ||
                  (st_r == S_RD && bit_r < BIT_ACK && !sh_r[7]); // RQ20

    // temperature code 12 is 25 C; codes above the table use its last entry, codes below it give no de-rating
    wire [4:0] t_cl = (temp_r < TCODE_TAB_FIRST) ? TCODE_TAB_FIRST :
                      (temp_r > TCODE_TAB_LAST) ? TCODE_TAB_LAST : temp_r; // RQ12
    wire [3:0] t_idx = 4'(t_cl - TCODE_TAB_FIRST);
    wire [3:0] nib = tab_r[{t_idx, 2'b00} +: 4]; // RQ9
    wire [3:0] steps = dmode_r[DMODE_2X_BIT] ? {nib[2:0], 1'b0} : {1'b0, nib[2:0]}; // RQ10
    wire below = temp_r < TCODE_TAB_FIRST;
    wire [7:0] dec = below ? 8'h00 : {4'h0, steps};
    wire [7:0] eff_dim = (dim_r > dec) ? dim_r - dec : 8'h00; // RQ13 RQ23
    wire take_meas = pend_r && !diag_req_i; // RQ16
    wire too_hot = fresh_r && ({3'b000, temp_r} > shdn_r); // RQ15

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_s_r <= 2'b11;
            sda_s_r <= 2'b11;
            sel_s_r <= 2'b00;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            // link pins and strap cross through two flops; only stage two is read
            scl_s_r <= {scl_s_r[0], bus.scl};
            sda_s_r <= {sda_s_r[0], bus.sda};
            sel_s_r <= {sel_s_r[0], address_select_pin_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    // two-wire slave; bits are taken on scl rising, the line changes after scl falls
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= S_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            mack_r <= 1'b1;
            wr_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            wr_r <= 1'b0;
            oe_r <= oe_nxt;
            if (start_ev) begin
                st_r <= S_ADDR;
                // the clock fall that closes the start wraps this to zero
                bit_r <= 4'hf;
            end else if (stop_ev) begin
                st_r <= S_IDLE; // RQ18
            end else if (st_r != S_IDLE) begin
                if (scl_rise && bit_r < BIT_ACK && st_r != S_RD) begin
                    sh_r <= {sh_r[6:0], sda_s_r[1]};
                end else if (scl_fall && bit_r < BIT_ACK && st_r == S_RD) begin
                    // read data moves on only under a low clock, never while scl is high
                    sh_r <= {sh_r[6:0], 1'b1};
                end else if (scl_rise && bit_r == BIT_ACK) begin
                    mack_r <= sda_s_r[1];
                end
                if (byte_end) begin
                    bit_r <= BIT_ACK;
                    if (st_r == S_ADDR && !addr_ok) begin
                        st_r <= S_IDLE;
                    end
                    wr_r <= st_r == S_WR; // RQ2
                end else if (ack_end) begin
                    bit_r <= 4'h0;
                    unique case (st_r)
                        S_ADDR: begin
                            st_r <= sh_r[0] ? S_RD : S_REG;
                            sh_r <= rd_data;
                        end
                        S_REG: begin
                            ptr_r <= sh_r;
                            st_r <= S_WR;
                        end
                        S_WR: ptr_r <= ptr_r + 8'h01;
                        S_RD: begin
                            // a master nack ends the read burst
                            if (mack_r) begin
                                st_r <= S_IDLE;
                            end
                            ptr_r <= ptr_r + 8'h01;
                        end
                        default: st_r <= S_IDLE;
                    endcase
                end else if (st_r == S_RD && ack_end == 1'b0 && scl_fall && bit_r == 4'h0 &&
                             mack_r == 1'b0 && sh_r == rd_data) begin
                    bit_r <= 4'h1;
                end else if (scl_fall) begin
                    bit_r <= bit_r + 4'h1;
                end
                if (ack_end && st_r == S_RD && !mack_r) begin
                    sh_r <= rd_data;
                end
            end
        end
    end

    // register file; writes land on the byte that completes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_r <= '{8'h00, 8'h00, 8'h00};
            en_r <= 6'h00;
            ot_r <= 1'b0;
            dim_r <= 8'h00;
            shdn_r <= SHDN_RST;
            dmode_r <= 8'h00;
            tab_r <= TAB_RST; // RQ17
        end else begin
            if (wr_r && hit_a) cur_r[0] <= sh_r; // RQ1
            if (wr_r && hit_b) cur_r[1] <= sh_r;
            if (wr_r && hit_c) cur_r[2] <= sh_r;
            if (wr_r && hit_dim) dim_r <= sh_r;
            if (wr_r && hit_sd) shdn_r <= sh_r;
            if (wr_r && hit_dm) dmode_r <= sh_r;
            if (wr_r && hit_tab) tab_r[{tab_wi, 3'b000} +: 8] <= sh_r;
            // cutoff beats a simultaneous enable write
            if (too_hot) begin
                en_r <= 6'h00; // RQ15
            end else if (wr_r && hit_en) begin
                en_r <= sh_r[5:0]; // RQ3
            end
            if (too_hot) begin
                ot_r <= 1'b1; // RQ22
            end
        end
    end

    // periodic temperature sampling sharing the converter with diagnostics
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_r <= 27'h0;
            pend_r <= 1'b0;
            fresh_r <= 1'b0;
            temp_r <= 5'h00;
            adc_diag_o <= 1'b0;
        end else begin
            tmr_r <= (tmr_r == 27'(TEMP_PERIOD - 1)) ? 27'h0 : tmr_r + 27'h1; // RQ14
            if (tmr_r == 27'(TEMP_PERIOD - 1)) begin
                pend_r <= 1'b1;
            end else if (take_meas) begin
                pend_r <= 1'b0;
            end
            if (take_meas) begin
                temp_r <= temp_code_i;
            end
            fresh_r <= take_meas;
            adc_diag_o <= diag_req_i && !take_meas; // RQ16
        end
    end

    ldd_log_pwm u_ldd_log_pwm (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .code_i(eff_dim),
        .pwm_o(pwm)
    ); // RQ5 RQ6 RQ8

    assign drive_nxt = en_r & {6{pwm}}; // RQ7

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {bank_c_out_2_o, bank_c_out_1_o, bank_b_out_2_o} <= 3'b000;
            {bank_b_out_1_o, bank_a_out_2_o, bank_a_out_1_o} <= 3'b000;
            led_current_a_o <= 8'h00;
            led_current_b_o <= 8'h00;
            led_current_c_o <= 8'h00;
            led_overheat_flag_o <= 1'b0;
            bus.s_sda_o <= 1'b0;
            bus.s_sda_oe <= 1'b0;
        end else begin
            {bank_c_out_2_o, bank_c_out_1_o, bank_b_out_2_o} <= drive_nxt[5:3];
            {bank_b_out_1_o, bank_a_out_2_o, bank_a_out_1_o} <= drive_nxt[2:0];
            led_current_a_o <= cur_r[0];
            led_current_b_o <= cur_r[1];
            led_current_c_o <= cur_r[2];
            led_overheat_flag_o <= ot_r;
            bus.s_sda_o <= 1'b0;
            bus.s_sda_oe <= oe_r;
        end
    end
endmodule // ldd_device

// *** ldd_host.sv ***
// host end: axi4-lite command registers driving a two-wire master
module ldd_host
    import ldd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    ldd_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_got_r, w_got_r;
    logic [7:0] awa_r;
    logic [31:0] wd_r;
    logic [6:0] dev_r;
    logic [7:0] reg_r, dat_r, rx_r;
    logic rd_r, nack_r;
    ldd_mst_t st_r;
    logic [1:0] q_r;
    logic [7:0] qc_r;
    logic [2:0] bi_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [1:0] sda_s_r;

    wire busy = st_r != M_IDLE;
    wire do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
    wire go = do_wr && awa_r == H_CMD && !busy && s_axi_wstrb[0]; // RQ4 RQ11 RQ21
    wire q_end = qc_r == 8'(I2C_QTR - 1);
    wire bit_end = q_end && q_r == 2'b11;
    wire last = rd_r ? bi_r == 3'h4 : bi_r == 3'h2;
    wire [7:0] tx = (bi_r == 3'h0) ? {dev_r, 1'b0} : (bi_r == 3'h1) ? reg_r :
                    (bi_r == 3'h2) ? dat_r : (bi_r == 3'h3) ? {dev_r, 1'b1} : 8'hff; // RQ2
    wire [31:0] rd_mux = (s_axi_araddr == H_STAT) ? {16'h0, rx_r, 6'h0, nack_r, busy} :
                         (s_axi_araddr == H_DEV) ? {25'h0, dev_r} : 32'h0;
    wire scl_nxt = (st_r == M_IDLE) || (q_r != 2'b00 && !(st_r != M_STOP && q_r == 2'b11));
    wire sda_nxt = (st_r == M_IDLE) ? 1'b1 : (st_r == M_START) ? !q_r[1] :
                   (st_r == M_STOP) ? q_r[1] : (bit_r < BIT_ACK ? sh_r[7] : 1'b1);

    // axi4-lite slave; write address and data may arrive in either order
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            dev_r <= SLV_ADDR_LO;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awa_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wd_r <= s_axi_wdata;
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awa_r == H_DEV && s_axi_wstrb[0]) dev_r <= wd_r[6:0];
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_got_r;
    assign s_axi_wready = !w_got_r;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;

    // bit engine: four quarters per bit, scl high in quarters one and two
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= M_IDLE;
            q_r <= 2'b00;
            qc_r <= 8'h00;
            bi_r <= 3'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            reg_r <= 8'h00;
            dat_r <= 8'h00;
            rd_r <= 1'b0;
            rx_r <= 8'h00;
            nack_r <= 1'b0;
            sda_s_r <= 2'b11;
        end else begin
            sda_s_r <= {sda_s_r[0], bus.sda};
            if (st_r != M_IDLE) begin
                qc_r <= q_end ? 8'h00 : qc_r + 8'h01;
                if (q_end) q_r <= q_r + 2'b01;
            end
            unique case (st_r)
                M_IDLE: if (go) begin
                    st_r <= M_START; // RQ20
                    bi_r <= 3'h0;
                    reg_r <= wd_r[7:0];
                    dat_r <= wd_r[15:8];
                    rd_r <= wd_r[CMD_RD_BIT];
                    nack_r <= 1'b0;
                end
                M_START: if (bit_end) begin
                    st_r <= M_BIT;
                    bit_r <= 4'h0;
                    sh_r <= tx;
                end
                M_BIT: begin
                    if (q_end && q_r == 2'b10) begin
                        if (bit_r < BIT_ACK) rx_r <= {rx_r[6:0], sda_s_r[1]};
                        else if (bi_r != 3'h4 && sda_s_r[1]) nack_r <= 1'b1;
                    end
                    if (bit_end) begin
                        sh_r <= {sh_r[6:0], 1'b1};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == BIT_ACK) begin
                            bit_r <= 4'h0;
                            sh_r <= (bi_r == 3'h1 && rd_r) ? tx : 8'hff;
                            if (nack_r || last) begin
                                st_r <= M_STOP;
                            end else if (rd_r && bi_r == 3'h1) begin
                                st_r <= M_START;
                                bi_r <= 3'h3;
                            end else begin
                                bi_r <= bi_r + 3'h1;
                                // the read data byte leaves sda released for the device
                                sh_r <= (bi_r == 3'h0) ? reg_r : (bi_r == 3'h3) ? 8'hff : dat_r;
                            end
                        end
                    end
                end
                M_STOP: if (bit_end) st_r <= M_IDLE;
            endcase
        end
    end

    // open drain: only ever pull low, release for high
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus.m_scl_o <= 1'b0;
            bus.m_sda_o <= 1'b0;
            bus.m_scl_oe <= 1'b0;
            bus.m_sda_oe <= 1'b0;
        end else begin
            bus.m_scl_o <= 1'b0;
            bus.m_sda_o <= 1'b0;
            bus.m_scl_oe <= !scl_nxt;
            bus.m_sda_oe <= !sda_nxt;
        end
    end
endmodule // ldd_host

// *** ldd_if.sv ***
// two-wire link between the host controller and the led driver
interface ldd_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    // open drain: a line is low when any enabled driver pulls it low
    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);
    modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input sda);
    modport dev (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// *** ldd_log_pwm.sv ***
// logarithmic duty mapping and 12-bit pwm counter
module ldd_log_pwm
    import ldd_pkg::*;
#(
    parameter int TICK = PWM_TICK
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] code_i,
    output logic pwm_o
);
    logic [7:0] pre_r;
    logic [DUTY_W-1:0] cnt_r;
    logic [14:0] expo;
    logic [12:0] mant;
    logic [12:0] duty;
    logic pwm_nxt;

    // 2^-x with linear fraction, x = steps * 0.17 dB in octaves
    assign expo = 15'(8'hff - code_i) * LOG_K;
    assign mant = 13'h1000 - {2'b00, expo[9:0], 1'b0};
    assign duty = (code_i == 8'h00) ? 13'h0000 : (mant >> expo[14:10]);
    assign pwm_nxt = {1'b0, cnt_r} < duty;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_r <= 8'h00;
            cnt_r <= '0;
            pwm_o <= 1'b0;
        end else begin
            pre_r <= (pre_r == 8'(TICK - 1)) ? 8'h00 : pre_r + 8'h01;
            if (pre_r == 8'(TICK - 1)) begin
                cnt_r <= cnt_r + 1'b1;
            end
            pwm_o <= pwm_nxt;
        end
    end
endmodule // ldd_log_pwm

// *** ldd_pkg.sv ***
// shared constants and types for the led dimming controller and its host
package ldd_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int DUTY_W = 12;
    localparam int PWM_HZ = 285;
    localparam int PWM_TICK = CLK_HZ / (PWM_HZ * (1 << DUTY_W));
    localparam int I2C_HZ = 400_000;
    // rounded up so the bit rate never exceeds the 400 kbit/s ceiling
    localparam int I2C_QTR = (CLK_HZ + I2C_HZ * 4 - 1) / (I2C_HZ * 4);
    localparam int TEMP_PERIOD_MS = 2500;
    localparam int TEMP_CYC = (CLK_HZ / 1000) * TEMP_PERIOD_MS;
    localparam logic [7:0] REG_CUR_A = 8'h00;
    localparam logic [7:0] REG_CUR_B = 8'h01;
    localparam logic [7:0] REG_CUR_C = 8'h02;
    localparam logic [7:0] REG_CH_EN = 8'h03;
    localparam logic [7:0] REG_DIM = 8'h05;
    localparam logic [7:0] REG_SHDN = 8'h4a;
    localparam logic [7:0] REG_DMODE = 8'h4b;
    localparam logic [7:0] REG_TAB0 = 8'h56;
    localparam logic [7:0] REG_TAB7 = 8'h5d;
    localparam logic [7:0] SHDN_RST = 8'h1c;
    localparam logic [63:0] TAB_RST = 64'h7777_7765_4321_0000;
    localparam logic [6:0] SLV_ADDR_LO = 7'h11;
    localparam logic [6:0] SLV_ADDR_HI = 7'h55;
    localparam int EN_OT_BIT = 7;
    localparam int DMODE_2X_BIT = 0;
    localparam logic [4:0] TCODE_TAB_FIRST = 5'h0c;
    localparam logic [4:0] TCODE_TAB_LAST = 5'h1b;
    localparam logic [14:0] LOG_K = 15'h001d;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] H_CMD = 8'h00;
    localparam logic [7:0] H_STAT = 8'h04;
    localparam logic [7:0] H_DEV = 8'h08;
    localparam int CMD_RD_BIT = 16;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_ADDR = 3'b001, S_REG = 3'b010, S_WR = 3'b011, S_RD = 3'b100
    } ldd_sst_t;
    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b10, M_STOP = 2'b11
    } ldd_mst_t;
endpackage

// *** ldd_tb.sv ***
// self-checking bench: host end and led driver joined over the two-wire link
module ldd_tb
    import ldd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] r; logic [7:0] w; logic [7:0] e;} ldd_row_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, cur_a, cur_b, cur_c;
    logic [31:0] wd = 32'h0, rd, st;
    logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic awr, wr, bv, arr, rv, a1, a2, b1, b2, c1, c2, ot, adcd;
    logic sel = 1'b0, diag = 1'b0;
    logic [4:0] tc = 5'h00;
    int fails = 0, tests_run = 0, cyc = 0;
    // unmapped device register must read zero and keep no value
    ldd_row_t rows [4] = '{'{8'h00, 8'ha0, 8'ha0}, '{8'h01, 8'hff, 8'hff},
        '{8'h02, 8'h01, 8'h01}, '{8'h04, 8'h55, 8'h00}};
    always #10 clk_i = ~clk_i;
    ldd_if bus();
    ldd_host u_ldd_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(),
        .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy));
    ldd_device #(.TEMP_PERIOD(200)) u_ldd_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .bus(bus), .address_select_pin_i(sel), .temp_code_i(tc), .diag_req_i(diag),
        .led_current_a_o(cur_a), .led_current_b_o(cur_b), .led_current_c_o(cur_c),
        .bank_a_out_1_o(a1), .bank_a_out_2_o(a2), .bank_b_out_1_o(b1),
        .bank_b_out_2_o(b2), .bank_c_out_1_o(c1), .bank_c_out_2_o(c2),
        .led_overheat_flag_o(ot), .adc_diag_o(adcd));
    ldd_chk u_ldd_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl(bus.scl), .sda(bus.sda),
        .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o),
        .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        brdy <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rd;
        rrdy <= 1'b0;
    endtask
    // one device register access, then poll until the link goes quiet
    task automatic dev(input logic [7:0] r, input logic [7:0] d, input logic rdn);
        axw(H_CMD, {15'h0000, rdn, d, r});
        do axr(H_STAT, st); while (st[0]);
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk("outs_rst", 8'h00, {ot, 1'b0, c2, c1, b2, b1, a2, a1});
        foreach (rows[i]) begin
            dev(rows[i].r, rows[i].w, 1'b0);
            dev(rows[i].r, 8'h00, 1'b1);
            chk("readback", rows[i].e, st[15:8]);
        end
        chk("cur_a", 8'ha0, cur_a);
        chk("cur_b", 8'hff, cur_b);
        chk("cur_c", 8'h01, cur_c);
        dev(REG_DIM, 8'hff, 1'b0);
        dev(REG_CH_EN, 8'h33, 1'b0);
        repeat (20) @(posedge clk_i);
        chk("full_duty", 8'h33, {2'b00, c2, c1, b2, b1, a2, a1});
        dev(REG_DMODE, 8'h01, 1'b0);
        tc <= 5'h1b;
        dev(REG_DIM, 8'h03, 1'b0);
        repeat (500) @(posedge clk_i);
        chk("derate_sat", 8'h00, {2'b00, c2, c1, b2, b1, a2, a1});
        chk("cur_kept", 8'ha0, cur_a);
        chk("derate_code", 8'h00, u_ldd_device.eff_dim);
        dev(REG_DMODE, 8'h00, 1'b0);
        dev(REG_DIM, 8'h10, 1'b0);
        chk("derate_1x", 8'h09, u_ldd_device.eff_dim);
        diag <= 1'b1;
        tc <= 5'h1d;
        repeat (400) @(posedge clk_i);
        chk("diag_own", 8'h01, {7'h00, adcd});
        chk("no_cut", 8'h00, {7'h00, ot});
        diag <= 1'b0;
        repeat (400) @(posedge clk_i);
        chk("cutoff", 8'h80, {ot, 1'b0, c2, c1, b2, b1, a2, a1});
        chk("cut_en", 8'h00, {2'b00, u_ldd_device.en_r});
        tc <= 5'h00;
        repeat (400) @(posedge clk_i);
        dev(REG_CH_EN, 8'h3f, 1'b0);
        dev(REG_CH_EN, 8'h00, 1'b1);
        chk("flag_kept", 8'hbf, st[15:8]);
        sel <= 1'b1;
        dev(REG_CUR_A, 8'h11, 1'b0);
        chk("nack", 8'h01, {7'h00, st[1]});
        axw(H_DEV, 32'h0000_0055);
        dev(REG_CUR_A, 8'h00, 1'b1);
        chk("addr_hi", 8'ha0, st[15:8]);
        rst_n_i <= 1'b0;
        sel <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("flag_rst", 8'h00, {7'h00, ot});
        rst_n_i <= 1'b1;
        dev(REG_TAB0 + 8'h02, 8'h00, 1'b1);
        chk("table_rst", 8'h21, st[15:8]);
        dev(REG_SHDN, 8'h00, 1'b1);
        chk("shdn_rst", 8'h1c, st[15:8]);
        finish_test();
    end
endmodule // ldd_tb
